// [dv/smd_issue_model.sv]
`timescale 1ns/1ps
`default_nettype none
module smd_issue_model (
  // Clock
  input  wire logic         mclk,
  // Request to the datapath
  output logic              req_valid,
  output smd_pkg::smd_req_t req
);
  import smd_pkg::*;
  // Idle issue slot from time zero
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  // One request for one taking edge; released operands are scrambled
  task automatic issue(input smd_req_t r);
    @(negedge mclk);
    req_valid = 1'b1;
    req = r;
    @(negedge mclk);
    req_valid = 1'b0;
    req = ~r;
  endtask
endmodule
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import smd_pkg::*;
  // ---------------------------------------------------------------
  // Clock, reset and instances
  // ---------------------------------------------------------------
  logic      mclk = 1'b0;
  logic      rst = 1'b1;
  logic      req_valid;
  smd_req_t  req;
  logic      resp_valid;
  smd_resp_t resp;
  smd_resp_t got;
  int        failures = 0;
  int        check_count = 0;
  smd_issue_model smd_issue_model_inst (.mclk(mclk), .req_valid(req_valid), .req(req));
  smd_datapath smd_datapath_inst (.mclk(mclk), .rst(rst), .req_valid(req_valid),
    .req(req), .resp_valid(resp_valid), .resp(resp));
  // Free running core clock
  initial begin
    forever #20 mclk = ~mclk;
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Issue one request and capture its one-cycle answer
  task automatic run(input smd_op_t op, input logic [7:0] imm, input logic [127:0] dst,
                     input logic [127:0] src, input logic mem = 1'b0,
                     input logic [3:0] alo = 4'h0, input logic ac = 1'b0);
    smd_req_t r;
    int       n;
    r = '{op, imm, dst, src, src[63:0], mem, alo, ac, RM_UP};
    smd_issue_model_inst.issue(r);
    n = 0;
    while (resp_valid !== 1'b1 && n < 3) begin
      @(negedge mclk);
      n++;
    end
    if (resp_valid !== 1'b1) begin
      failures++;
      wrap_up();
    end
    got = resp;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_round();
    logic [7:0] im [6] = '{8'h0, 8'h1, 8'h2, 8'h3, 8'h4, 8'ha};
    for (int k = 0; k < 6; k++) begin
      run(OP_ROUND_SCALAR_SINGLE, im[k], '0, 128'h40200000);
      chk(got.vec, (k == 2 || k > 3) ? 128'h40400000 : 128'h40000000);
      chk(got.inexact, 128'(k != 5));
    end
    // Packed double toward minus infinity: 1.5 and -2.5
    run(OP_ROUND_PACKED_DOUBLE, 8'h1, '0, {64'hc004000000000000, 64'h3ff8000000000000});
    chk(got.vec, {64'hc008000000000000, 64'h3ff0000000000000});
    $display("round done");
  endtask
  task automatic t_test();
    run(OP_PACKED_BIT_TEST, 8'h0, 128'hf0, 128'h0f);
    chk({got.zero_flag, got.carry_flag, got.vec_we, got.flags_we}, 4'b1001);
    run(OP_PACKED_BIT_TEST, 8'h0, 128'hf0, 128'hff);
    chk({got.zero_flag, got.carry_flag, got.vec_we, got.flags_we}, 4'b0101);
    run(OP_HORIZONTAL_MIN_WORD, 8'h0, '0, 128'h0009_0003_0007_0003_ffff_0005_0008_0006);
    chk(got.vec, 128'h4_0003);
    $display("test and minimum done");
  endtask
  task automatic t_widen();
    run(OP_SEXT_BYTE_TO_WORD, 8'h0, '0, 128'h7f80_0102_03fe_ff00);
    chk(got.vec, 128'h007f_ff80_0001_0002_0003_fffe_ffff_0000);
    chk({got.vec_we, got.gpr_we}, 2'b10);
    run(OP_ZEXT_BYTE_TO_WORD, 8'h0, '0, 128'h7f80_0102_03fe_ff00);
    chk(got.vec, 128'h007f_0080_0001_0002_0003_00fe_00ff_0000);
    run(OP_SEXT_BYTE_TO_DWORD, 8'h0, '0, 128'h03fe_ff00, 1'b1, 4'h2, 1'b1);
    chk({got.align_fault, got.vec_we}, 2'b10);
    run(OP_SEXT_BYTE_TO_DWORD, 8'h0, '0, 128'h03fe_ff00, 1'b1, 4'h2, 1'b0);
    chk(got.vec, 128'h00000003_fffffffe_ffffffff_00000000);
    $display("widen done");
  endtask
  task automatic t_sad();
    logic [127:0] d;
    logic [127:0] s;
    logic [127:0] e;
    int           a;
    int           x;
    int           y;
    for (int i = 0; i < 16; i++) begin
      d[8*i+:8] = 8'(i * 9);
      s[8*i+:8] = 8'(90 - i * 7);
    end
    // Immediate 2: block 2 at start 0; immediate 5: block 1 at start 4
    for (int m = 2; m < 6; m += 3) begin
      for (int i = 0; i < 8; i++) begin
        a = 0;
        for (int j = 0; j < 4; j++) begin
          x = int'(d[8*((m / 4) * 4 + i + j)+:8]);
          y = int'(s[8*((m % 4) * 4 + j)+:8]);
          a += (x > y) ? x - y : y - x;
        end
        e[16*i+:16] = 16'(a);
      end
      run(OP_MULTI_ABS_DIFF_SUM, 8'(m), d, s);
      chk(got.vec, e);
    end
    $display("sum of differences done");
  endtask
  task automatic t_move();
    run(OP_FLOAT_ELEMENT_INSERT, 8'h98, {4{32'h44444444}}, {32'hd, 32'hc, 32'hb, 32'ha});
    chk(got.vec, 128'h00000000_44444444_0000000c_44444444);
    run(OP_INT_INSERT_DWORD, 8'h2, {4{32'h44444444}}, 128'h12345678);
    chk(got.vec, 128'h44444444_12345678_44444444_44444444);
    run(OP_INT_EXTRACT_WORD, 8'h3, 128'h0b0a0908_07060504_03020100, '0);
    chk({got.general_register, got.gpr_we}, {64'h0706, 1'b1});
    run(OP_INT_EXTRACT_BYTE, 8'h9, 128'h0b0a0908_07060504_03020100, '0);
    chk({got.general_register, got.gpr_we}, {64'h09, 1'b1});
    run(OP_INT_INSERT_QWORD, 8'h1, '0, 128'h1122334455667788);
    chk(got.vec, {64'h1122334455667788, 64'h0});
    run(OP_INT_EXTRACT_DWORD, 8'h0, '0, '0, 1'b1, 4'h2, 1'b1);
    chk({got.align_fault, got.gpr_we}, 2'b10);
    run(OP_FLOAT_ELEMENT_EXTRACT, 8'h2, {32'h0b0a0908, 64'h0}, '0, 1'b1, 4'h1, 1'b0);
    chk({got.general_register, got.align_fault}, {64'h0b0a0908, 1'b0});
    $display("insert and extract done");
  endtask
  // Reset for three cycles, then every scenario
  initial begin
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    t_round();
    t_test();
    t_widen();
    t_sad();
    t_move();
    wrap_up();
  end
endmodule
`default_nettype wire

// [inc/smd_pkg.sv]
`default_nettype none
package smd_pkg;

  // ----------------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_ROUND_SCALAR_SINGLE = 5'h00,
    OP_ROUND_SCALAR_DOUBLE = 5'h01,
    OP_ROUND_PACKED_SINGLE = 5'h02,
    OP_ROUND_PACKED_DOUBLE = 5'h03,
    OP_FLOAT_ELEMENT_EXTRACT = 5'h04,
    OP_FLOAT_ELEMENT_INSERT = 5'h05,
    OP_INT_INSERT_BYTE     = 5'h06,
    OP_INT_INSERT_WORD     = 5'h07,
    OP_INT_INSERT_DWORD    = 5'h08,
    OP_INT_INSERT_QWORD    = 5'h09,
    OP_INT_EXTRACT_BYTE    = 5'h0a,
    OP_INT_EXTRACT_WORD    = 5'h0b,
    OP_INT_EXTRACT_DWORD   = 5'h0c,
    OP_INT_EXTRACT_QWORD   = 5'h0d,
    OP_SEXT_BYTE_TO_WORD   = 5'h0e,
    OP_ZEXT_BYTE_TO_WORD   = 5'h0f,
    OP_SEXT_BYTE_TO_DWORD  = 5'h10,
    OP_ZEXT_BYTE_TO_DWORD  = 5'h11,
    OP_SEXT_BYTE_TO_QWORD  = 5'h12,
    OP_ZEXT_BYTE_TO_QWORD  = 5'h13,
    OP_SEXT_WORD_TO_DWORD  = 5'h14,
    OP_ZEXT_WORD_TO_DWORD  = 5'h15,
    OP_SEXT_WORD_TO_QWORD  = 5'h16,
    OP_ZEXT_WORD_TO_QWORD  = 5'h17,
    OP_SEXT_DWORD_TO_QWORD = 5'h18,
    OP_ZEXT_DWORD_TO_QWORD = 5'h19,
    OP_MULTI_ABS_DIFF_SUM  = 5'h1a,
    OP_HORIZONTAL_MIN_WORD = 5'h1b,
    OP_PACKED_BIT_TEST     = 5'h1c
  } smd_op_t;

  // Rounding modes as coded in the immediate and in core control state
  typedef enum logic [1:0] {
    RM_NEAREST = 2'h0,
    RM_DOWN    = 2'h1,
    RM_UP      = 2'h2,
    RM_TRUNC   = 2'h3
  } smd_rmode_t;

  // ----------------------------------------------------------------------
  // Immediate field positions
  // ----------------------------------------------------------------------
  localparam int IMM_RMODE_LO   = 0;  // Rounding mode, 2 bits
  localparam int IMM_USE_CUR    = 2;  // Use core rounding mode
  localparam int IMM_NO_INEXACT = 3;  // Suppress inexact signalling
  localparam int IMM_ZMASK_LO   = 0;  // Float insert zero mask, 4 bits
  localparam int IMM_INS_DST_LO = 4;  // Float insert destination slot
  localparam int IMM_INS_SRC_LO = 6;  // Float insert source slot
  localparam int IMM_SAD_BLK_LO = 0;  // Source block select, 2 bits
  localparam int IMM_SAD_DST    = 2;  // Destination byte offset select
  localparam int SAD_DST_STEP   = 4;  // Destination offset step, bytes
  localparam int MIN_IDX_LO     = 16; // Position field of minimum result

  // ----------------------------------------------------------------------
  // Request and response carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    smd_op_t      op;
    logic [7:0]   imm;
    logic [127:0] vec_dst;     // Destination register operand
    logic [127:0] vec_src;     // Source register or loaded memory
    logic [63:0]  gpr_in;      // General register or loaded scalar
    logic         mem_op;      // Operand lives in memory
    logic [3:0]   addr_lo;     // Low address bits of memory operand
    logic         align_check; // Alignment checking enabled
    smd_rmode_t   cur_rmode;   // Core current rounding mode
  } smd_req_t;

  typedef struct packed {
    logic         valid;
    logic [127:0] vec;
    logic         vec_we;
    logic [63:0]  general_register;
    logic         gpr_we;
    logic         zero_flag;
    logic         carry_flag;
    logic         flags_we;
    logic         inexact;
    logic         align_fault;
  } smd_resp_t;

  localparam smd_resp_t RESP_RESET = '0;

endpackage
`default_nettype wire

// [rtl/smd_datapath.sv]
// Functional notes
// - Rounds scalar single, scalar double, packed single and packed double.
// - Immediate picks nearest, down, up or truncate; core mode untouched.
// - An immediate bit makes rounding use the core current mode.
// - A separate immediate bit suppresses the inexact signal.
// - Insert and extract memory accesses fault only if alignment checking.
// - Float extract moves any dword of a vector to memory or register.
// - Float insert places memory dword or chosen vector element in slot.
// - Float insert writes positive zero into masked destination slots.
// - Integer insert writes byte, word, dword or qword into a vector element.
// - Integer extract reads byte, word, dword or qword to a register.
// - Twelve sign or zero widening variants across byte, word, dword.
// - Widening reads register or memory and writes a vector unless it faults on alignment.
// - Widening element counts and memory widths follow the fixed table.
// - Widening memory must align to its width when checking is on.
// - Multi sum of absolute differences gives eight 16-bit sums.
// - Two immediate bits pick the 4-byte source block.
// - One immediate bit starts eleven destination bytes at 0 or 4.
// - Horizontal minimum finds smallest of eight words and its position.
// - Minimum value and position pack into the low dword.
// - Packed test sets zero flag when destination AND mask is zero.
// - Packed test sets carry flag when destination AND NOT mask is zero.
// - Packed test writes only flags, never the destination.
`timescale 1ns/1ps
`default_nettype none
module smd_datapath (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // Request from issue
  input  wire logic                req_valid,
  input  wire smd_pkg::smd_req_t   req,
  // Result to register file and flags
  output logic                     resp_valid,
  output smd_pkg::smd_resp_t       resp
);
  import smd_pkg::*;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Widen packed elements of width fw into width tw
  function automatic logic [127:0] widen(input logic [127:0] s, input int fw,
                                         input int tw, input logic sx);
    logic [127:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      for (int b = 0; b < 64; b++) begin
        if (i < 128 / tw && b < tw) begin
          if (b < fw) begin
            r[i*tw+b] = s[i*fw+b];
          end else begin
            r[i*tw+b] = sx & s[i*fw+fw-1];
          end
        end
      end
    end
    // Byte to word has eight elements, handled by the loop above
    return r;
  endfunction

  // True when the low address bits break natural alignment
  function automatic logic misaligned(input logic [3:0] a, input int bytes);
    return (a & 4'(bytes - 1)) != 4'h0;
  endfunction

  // Absolute difference of two bytes
  function automatic logic [7:0] abs_diff(input logic [7:0] x, input logic [7:0] y);
    return (x > y) ? x - y : y - x;
  endfunction

  // One 4-byte sum at destination byte base
  function automatic logic [15:0] sad4(input logic [127:0] d, input int base,
                                       input logic [31:0] blk);
    logic [15:0] s;
    s = '0;
    for (int j = 0; j < 4; j++) begin
      s = s + 16'(abs_diff(d[(base+j)*8 +: 8], blk[j*8 +: 8]));
    end
    return s;
  endfunction

  // ----------------------------------------------------------------------
  // Rounding lanes
  // ----------------------------------------------------------------------
  smd_rmode_t   rmode;
  logic [127:0] rnd_single;
  logic [127:0] rnd_double;
  logic [3:0]   inx_single;
  logic [1:0]   inx_double;

  always_comb begin
    if (req.imm[IMM_USE_CUR]) begin
      rmode = req.cur_rmode;
    end else begin
      rmode = smd_rmode_t'(req.imm[IMM_RMODE_LO +: 2]);
    end
  end

  // four single and two double lanes
  for (genvar g = 0; g < 4; g++) begin : g_single
    smd_round_elem #(.EXP_W(8), .MAN_W(23)) u_rnd (
      .value   (req.vec_src[g*32 +: 32]),
      .mode    (rmode),
      .result  (rnd_single[g*32 +: 32]),
      .inexact (inx_single[g])
    );
  end
  for (genvar g = 0; g < 2; g++) begin : g_double
    smd_round_elem #(.EXP_W(11), .MAN_W(52)) u_rnd (
      .value   (req.vec_src[g*64 +: 64]),
      .mode    (rmode),
      .result  (rnd_double[g*64 +: 64]),
      .inexact (inx_double[g])
    );
  end

  // ----------------------------------------------------------------------
  // Operation datapath
  // ----------------------------------------------------------------------
  smd_resp_t    state;
  smd_resp_t    next_state;
  logic [127:0] ins_vec;
  logic [31:0]  ins_val;
  logic [31:0]  sad_blk;
  logic [15:0]  min_val;
  logic [2:0]   min_idx;
  int           sad_base;
  int           mem_bytes;

  // Result of the request presented this cycle
  always_comb begin
    next_state       = RESP_RESET;
    next_state.valid = req_valid;
    ins_vec          = req.vec_dst;
    ins_val          = '0;
    sad_blk          = '0;
    min_val          = req.vec_src[15:0];
    min_idx          = 3'h0;
    sad_base         = 0;
    mem_bytes        = 1;
    case (req.op)
      OP_ROUND_SCALAR_SINGLE: begin
        next_state.vec     = {req.vec_dst[127:32], rnd_single[31:0]};
        next_state.vec_we  = 1'b1;
        next_state.inexact = inx_single[0] & ~req.imm[IMM_NO_INEXACT];
      end
      OP_ROUND_SCALAR_DOUBLE: begin
        next_state.vec     = {req.vec_dst[127:64], rnd_double[63:0]};
        next_state.vec_we  = 1'b1;
        next_state.inexact = inx_double[0] & ~req.imm[IMM_NO_INEXACT];
      end
      OP_ROUND_PACKED_SINGLE: begin
        next_state.vec     = rnd_single;
        next_state.vec_we  = 1'b1;
        next_state.inexact = (|inx_single) & ~req.imm[IMM_NO_INEXACT];
      end
      OP_ROUND_PACKED_DOUBLE: begin
        next_state.vec     = rnd_double;
        next_state.vec_we  = 1'b1;
        next_state.inexact = (|inx_double) & ~req.imm[IMM_NO_INEXACT];
      end
      OP_FLOAT_ELEMENT_EXTRACT: begin
        // any dword to register or store
        next_state.general_register    = {32'h0, req.vec_dst[req.imm[1:0]*32 +: 32]};
        next_state.gpr_we = 1'b1;
        mem_bytes         = 4;
      end
      OP_FLOAT_ELEMENT_INSERT: begin
        // memory dword or chosen source slot
        if (req.mem_op) begin
          ins_val = req.vec_src[31:0];
        end else begin
          ins_val = req.vec_src[req.imm[IMM_INS_SRC_LO +: 2]*32 +: 32];
        end
        ins_vec[req.imm[IMM_INS_DST_LO +: 2]*32 +: 32] = ins_val;
        for (int k = 0; k < 4; k++) begin
          if (req.imm[IMM_ZMASK_LO+k]) begin
            ins_vec[k*32 +: 32] = 32'h0;
          end
        end
        next_state.vec    = ins_vec;
        next_state.vec_we = 1'b1;
        mem_bytes         = 4;
      end
      OP_INT_INSERT_BYTE: begin
        ins_vec[req.imm[3:0]*8 +: 8] = req.gpr_in[7:0];
        next_state.vec    = ins_vec;
        next_state.vec_we = 1'b1;
      end
      OP_INT_INSERT_WORD: begin
        ins_vec[req.imm[2:0]*16 +: 16] = req.gpr_in[15:0];
        next_state.vec    = ins_vec;
        next_state.vec_we = 1'b1;
        mem_bytes         = 2;
      end
      OP_INT_INSERT_DWORD: begin
        ins_vec[req.imm[1:0]*32 +: 32] = req.gpr_in[31:0];
        next_state.vec    = ins_vec;
        next_state.vec_we = 1'b1;
        mem_bytes         = 4;
      end
      OP_INT_INSERT_QWORD: begin
        ins_vec[req.imm[0]*64 +: 64] = req.gpr_in;
        next_state.vec    = ins_vec;
        next_state.vec_we = 1'b1;
        mem_bytes         = 8;
      end
      OP_INT_EXTRACT_BYTE: begin
        next_state.general_register    = {56'h0, req.vec_dst[req.imm[3:0]*8 +: 8]};
        next_state.gpr_we = 1'b1;
      end
      OP_INT_EXTRACT_WORD: begin
        next_state.general_register    = {48'h0, req.vec_dst[req.imm[2:0]*16 +: 16]};
        next_state.gpr_we = 1'b1;
        mem_bytes         = 2;
      end
      OP_INT_EXTRACT_DWORD: begin
        next_state.general_register    = {32'h0, req.vec_dst[req.imm[1:0]*32 +: 32]};
        next_state.gpr_we = 1'b1;
        mem_bytes         = 4;
      end
      OP_INT_EXTRACT_QWORD: begin
        next_state.general_register    = req.vec_dst[req.imm[0]*64 +: 64];
        next_state.gpr_we = 1'b1;
        mem_bytes         = 8;
      end
      OP_SEXT_BYTE_TO_WORD, OP_ZEXT_BYTE_TO_WORD: begin
        next_state.vec = widen(req.vec_src, 8, 16, ~req.op[0]);
        mem_bytes      = 8;
      end
      OP_SEXT_BYTE_TO_DWORD, OP_ZEXT_BYTE_TO_DWORD: begin
        next_state.vec = widen(req.vec_src, 8, 32, ~req.op[0]);
        mem_bytes      = 4;
      end
      OP_SEXT_BYTE_TO_QWORD, OP_ZEXT_BYTE_TO_QWORD: begin
        next_state.vec = widen(req.vec_src, 8, 64, ~req.op[0]);
        mem_bytes      = 2;
      end
      OP_SEXT_WORD_TO_DWORD, OP_ZEXT_WORD_TO_DWORD: begin
        next_state.vec = widen(req.vec_src, 16, 32, ~req.op[0]);
        mem_bytes      = 8;
      end
      OP_SEXT_WORD_TO_QWORD, OP_ZEXT_WORD_TO_QWORD: begin
        next_state.vec = widen(req.vec_src, 16, 64, ~req.op[0]);
        mem_bytes      = 4;
      end
      OP_SEXT_DWORD_TO_QWORD, OP_ZEXT_DWORD_TO_QWORD: begin
        next_state.vec = widen(req.vec_src, 32, 64, ~req.op[0]);
        mem_bytes      = 8;
      end
      OP_MULTI_ABS_DIFF_SUM: begin
        sad_blk  = req.vec_src[req.imm[IMM_SAD_BLK_LO +: 2]*32 +: 32];
        // eleven bytes from offset 0 or 4
        sad_base = req.imm[IMM_SAD_DST] ? SAD_DST_STEP : 0;
        for (int i = 0; i < 8; i++) begin
          next_state.vec[i*16 +: 16] = sad4(req.vec_dst, sad_base + i, sad_blk);
        end
        next_state.vec_we = 1'b1;
      end
      OP_HORIZONTAL_MIN_WORD: begin
        for (int i = 1; i < 8; i++) begin
          if (req.vec_src[i*16 +: 16] < min_val) begin
            min_val = req.vec_src[i*16 +: 16];
            min_idx = 3'(i);
          end
        end
        // value and position in low dword
        next_state.vec[15:0]                = min_val;
        next_state.vec[MIN_IDX_LO +: 3]     = min_idx;
        next_state.vec_we                   = 1'b1;
      end
      OP_PACKED_BIT_TEST: begin
        next_state.zero_flag  = (req.vec_dst & req.vec_src) == '0;
        next_state.carry_flag = (req.vec_dst & ~req.vec_src) == '0;
        next_state.flags_we   = 1'b1;
      end
      default: begin
        next_state.vec_we = 1'b0;
      end
    endcase
    if (req.op >= OP_SEXT_BYTE_TO_WORD && req.op <= OP_ZEXT_DWORD_TO_QWORD) begin
      next_state.vec_we = 1'b1;
    end
    // insert, extract and widening aligned to their memory width
    if (req.mem_op && req.align_check && misaligned(req.addr_lo, mem_bytes) &&
        req.op >= OP_FLOAT_ELEMENT_EXTRACT && req.op <= OP_ZEXT_DWORD_TO_QWORD) begin
      next_state.align_fault = 1'b1;
      next_state.vec_we      = 1'b0;
      next_state.gpr_we      = 1'b0;
    end
    if (!req_valid) begin
      next_state = RESP_RESET;
    end
  end

  // Result register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= RESP_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Both outputs come straight from the one result register
  assign resp       = state;
  assign resp_valid = state.valid;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_req(smd_op_t o);
    req_valid && req.op == o;
  endsequence

  a_packed_bit_test_zero: assert property (s_req(OP_PACKED_BIT_TEST) |=>
    resp.zero_flag == (($past(req.vec_dst) & $past(req.vec_src)) == '0))
    else $error("zero flag wrong after packed test");
  a_packed_bit_test_carry: assert property (s_req(OP_PACKED_BIT_TEST) |=>
    resp.carry_flag == (($past(req.vec_dst) & ~$past(req.vec_src)) == '0))
    else $error("carry flag wrong after packed test");
  a_packed_bit_test_no_write: assert property (s_req(OP_PACKED_BIT_TEST) |=>
    resp.flags_we && !resp.vec_we && !resp.gpr_we)
    else $error("packed test wrote a register");
  a_hmin_upper_clear: assert property (s_req(OP_HORIZONTAL_MIN_WORD) |=>
    resp.vec[127:19] == '0 && resp.vec[15:0] <= $past(req.vec_src[15:0]))
    else $error("minimum result upper bits or value wrong");
  a_round_no_inexact: assert property (
    req_valid && req.op <= OP_ROUND_PACKED_DOUBLE && req.imm[IMM_NO_INEXACT]
    |=> !resp.inexact && resp.vec_we)
    else $error("inexact signalled while suppressed");
  a_fins_zero_mask: assert property (
    s_req(OP_FLOAT_ELEMENT_INSERT) && req.imm[IMM_ZMASK_LO] && !req.align_check
    |=> resp.vec[31:0] == 32'h0)
    else $error("masked slot not zero after float insert");
  a_fext_select: assert property (s_req(OP_FLOAT_ELEMENT_EXTRACT) && !req.mem_op
    |=> resp.general_register[31:0] == $past(req.vec_dst[req.imm[1:0]*32 +: 32]) && resp.gpr_we)
    else $error("float extract picked the wrong dword");
  a_widen_align: assert property (
    req_valid && req.op == OP_SEXT_BYTE_TO_WORD && req.mem_op &&
    req.align_check && req.addr_lo[2:0] != 3'h0
    |=> resp.align_fault && !resp.vec_we)
    else $error("misaligned widening not faulted");
  a_widen_vec_write: assert property (
    req_valid && req.op >= OP_SEXT_BYTE_TO_WORD && req.op <= OP_ZEXT_DWORD_TO_QWORD &&
    !req.align_check |=> resp.vec_we && !resp.gpr_we)
    else $error("widening did not write a vector");
  // Every taken request answers exactly one cycle later
  a_valid_latency: assert property (req_valid |=> resp_valid ##1 !resp_valid || $past(req_valid))
    else $error("result valid not one cycle after request");

endmodule
`default_nettype wire

// [rtl/smd_round_elem.sv]
`timescale 1ns/1ps
`default_nettype none
module smd_round_elem #(
  parameter int EXP_W = 8,
  parameter int MAN_W = 23
) (
  // Operand and mode
  input  wire logic [EXP_W+MAN_W:0] value,
  input  wire smd_pkg::smd_rmode_t  mode,
  // Rounded result
  output logic      [EXP_W+MAN_W:0] result,
  output logic                      inexact
);
  import smd_pkg::*;

  localparam int W    = MAN_W + 2;
  localparam int BIAS = (1 << (EXP_W - 1)) - 1;

  logic             sign;
  logic [EXP_W-1:0] expf;
  logic [MAN_W-1:0] man;
  logic [W-1:0]     full;
  logic [W-1:0]     mask;
  logic [W-1:0]     frac;
  logic [W-1:0]     half;
  logic [W-1:0]     ipart;
  logic [W-1:0]     shifted;
  logic             up;
  logic             nz;
  int               e;
  int               fb;

  // Round to an integral value in the same format
  always_comb begin
    sign    = value[EXP_W+MAN_W];
    expf    = value[MAN_W +: EXP_W];
    man     = value[MAN_W-1:0];
    e       = int'(expf) - BIAS;
    full    = {2'b01, man};
    result  = value;
    inexact = 1'b0;
    up      = 1'b0;
    nz      = (expf != '0) || (man != '0);
    fb      = 1;
    mask    = '0;
    frac    = '0;
    half    = '0;
    ipart   = '0;
    shifted = '0;
    if (expf == '1 || e >= MAN_W) begin
      result = value;
    end else if (e < 0) begin
      // Magnitude below one: result is zero or one
      inexact = nz;
      case (mode)
        RM_NEAREST: up = (e == -1) && (man != '0);
        RM_DOWN:    up = sign && nz;
        RM_UP:      up = !sign && nz;
        default:    up = 1'b0;
      endcase
      result = {sign, (up ? EXP_W'(BIAS) : EXP_W'(0)), MAN_W'(0)};
    end else begin
      fb      = MAN_W - e;
      mask    = (W'(1) << fb) - W'(1);
      frac    = full & mask;
      half    = W'(1) << (fb - 1);
      ipart   = full >> fb;
      inexact = (frac != '0);
      case (mode)
        RM_NEAREST: up = (frac > half) || ((frac == half) && ipart[0]);
        RM_DOWN:    up = sign && inexact;
        RM_UP:      up = !sign && inexact;
        default:    up = 1'b0;
      endcase
      shifted = (ipart + W'(up)) << fb;
      if (shifted[W-1]) begin
        result = {sign, expf + EXP_W'(1), MAN_W'(0)};
      end else begin
        result = {sign, expf, shifted[MAN_W-1:0]};
      end
    end
  end

endmodule
`default_nettype wire
